// ===== logic/pcm_ctl_pkg.sv
// ****************************************
// register map, fields and encodings
// ****************************************
package pcm_ctl_pkg;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  // control_status field positions
  localparam int CS_EN = 0;
  localparam int CS_RX_RUN = 1;
  localparam int CS_TX_RUN = 2;
  localparam int CS_TX_CLR = 3;
  localparam int CS_RX_CLR = 4;
  localparam int CS_THR_LO = 5;
  localparam int CS_THR_HI = 6;
  localparam int CS_TXW = 17;
  localparam int CS_TXD = 19;
  localparam int CS_RXD = 20;
  localparam int CS_TXE = 21;
  localparam int CS_RXF = 22;
  // operating_mode field positions
  localparam int MD_SLAVE = 23;
  localparam int MD_TXP = 24;
  localparam int MD_RXP = 25;
  localparam int MD_PDM = 26;
  localparam int MD_DEC = 27;
  localparam int MD_CLKOFF = 28;
  // reset values
  localparam logic [1:0] THR_RST = 2'h0;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [31:0] DATA_RST = 32'h00000000;
  // transmit threshold codes
  localparam logic [1:0] THR_EMPTY = 2'h0;
  localparam logic [1:0] THR_QUARTER = 2'h1;
  localparam logic [1:0] THR_ALMOST = 2'h2;
  // decimation ratios
  localparam logic [5:0] DEC_LOW = 6'h10;
  localparam logic [5:0] DEC_HIGH = 6'h20;
  // frame engine states
  typedef enum logic [1:0] {
    FR_IDLE = 2'b01,
    FR_RUN = 2'b10
  } frame_state_e;
endpackage : pcm_ctl_pkg

// ===== logic/ram_if.sv
`timescale 1ns/1ns
// ****************************************
// fifo storage port
// ****************************************
interface ram_if #(
  parameter int W = 32,
  parameter int AW = 6
) ();
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ram_if

// ===== logic/fifo_mem.sv
`timescale 1ns/1ns
// ****************************************
// fifo storage, registered read, write-first
// ****************************************
module fifo_mem #(
  parameter int W = 32,
  parameter int AW = 6
) (
  input wire logic core_clk,
  input wire logic resetn,
  ram_if.mem port
);
  logic [W-1:0] store [0:(1<<AW)-1];
  logic [W-1:0] rd_r;
  logic [W-1:0] rd_nxt;

  // bypass so a word written this cycle is seen at once
  always_comb begin
    if (port.we && port.waddr == port.raddr) begin
      rd_nxt = port.wdata;
    end else begin
      rd_nxt = store[port.raddr];
    end
  end

  // array write
  always_ff @(posedge core_clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end

  // read register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign port.rdata = rd_r;
endmodule : fifo_mem

// ===== logic/cic_decim.sv
`timescale 1ns/1ns
// ****************************************
// single-stage decimator for density input
// ****************************************
module cic_decim (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic sample,
  input wire logic din,
  input wire logic ratio_high,
  output logic valid,
  output logic [15:0] data
);
  logic [5:0] cnt_r, cnt_nxt;
  logic [5:0] acc_r, acc_nxt;
  logic [15:0] data_r, data_nxt;
  logic valid_r, valid_nxt;
  logic [5:0] ratio;

  // integrate ones, dump every ratio samples
  always_comb begin
    ratio = ratio_high ? pcm_ctl_pkg::DEC_HIGH : pcm_ctl_pkg::DEC_LOW;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    data_nxt = data_r;
    valid_nxt = 1'b0;
    if (!enable) begin
      cnt_nxt = '0;
      acc_nxt = '0;
    end else if (sample) begin
      if (cnt_r == ratio - 6'h01) begin
        data_nxt = 16'(acc_r + 6'(din));
        valid_nxt = 1'b1;
        cnt_nxt = '0;
        acc_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 6'h01;
        acc_nxt = acc_r + 6'(din);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      acc_r <= '0;
      data_r <= '0;
      valid_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      data_r <= data_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign valid = valid_r;
  assign data = data_r;
endmodule : cic_decim

// ===== logic/audio_pcm_control_mode.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
// Behaviour
// - threshold selects when needs-writing flag rises
// - receive clear empties receive fifo, reads zero
// - transmit clear empties transmit fifo, reads zero
// - tx_run off stops at frame end
// - tx_run on starts next frame, channel aligned
// - frame counter starts on either run bit
// - rx_run off stops at frame end
// - rx_run on starts next frame, first channel first
// - global enable low gates interface off
// - one data port pushes tx, pops rx
// - bit_clock_off stops clock without glitch
// - decimation_ratio_sel picks ratio 16 or 32
// - density input routes pin through decimator
// - rx packed merges channels, low half first
// - tx packed splits word, low half first
// - clock mode picks driven or received clock
// - needs-writing follows fill level versus threshold
// - only low three control bits change while running
module audio_pcm_control_mode #(
  parameter int DEPTH = 64,
  parameter int CH_BITS = 32,
  parameter int HALF_DIV = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  output logic fs_o,
  output logic dout_o,
  input wire logic din_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(2 * CH_BITS);
  localparam int DW = $clog2(HALF_DIV + 1);

  // ****************************************
  // declarations
  // ****************************************
  logic bclk_s1, bclk_s2, bclk_s3, din_s1, din_s2;
  logic [DW-1:0] div_r, div_nxt;
  logic mb_r, mb_nxt, mrise, mfall, rise, fall;
  pcm_ctl_pkg::frame_state_e st_r, st_nxt;
  logic [CW-1:0] bit_cnt_r, bit_cnt_nxt;
  logic tx_act_r, tx_act_nxt, rx_act_r, rx_act_nxt;
  logic [CH_BITS-1:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
  logic [15:0] tx_hold_r, tx_hold_nxt, rx_hold_r, rx_hold_nxt;
  logic fs_r, fs_nxt, dout_r, dout_nxt;
  logic fstart, ch_start, last, tx_pop, rx_push, run_req;
  logic [31:0] rx_push_data;
  logic en_r, en_nxt, rx_run_r, rx_run_nxt, tx_run_r, tx_run_nxt;
  logic [1:0] thr_r, thr_nxt;
  logic [5:0] mode_r, mode_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [AW-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [AW-1:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  logic [AW:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
  logic wr_ctrl, wr_data, wr_mode, rd_data, tx_push, rx_pop, tx_clr, rx_clr;
  logic tx_needs_writing, running, slave, clk_off, tx_packed, rx_packed, pdm;
  logic cic_valid;
  logic [15:0] cic_data;

  ram_if #(.W(32), .AW(AW)) tx_ram ();
  ram_if #(.W(32), .AW(AW)) rx_ram ();

  assign slave = mode_r[pcm_ctl_pkg::MD_SLAVE - 23];
  assign tx_packed = mode_r[pcm_ctl_pkg::MD_TXP - 23];
  assign rx_packed = mode_r[pcm_ctl_pkg::MD_RXP - 23];
  assign pdm = mode_r[pcm_ctl_pkg::MD_PDM - 23];
  assign clk_off = mode_r[pcm_ctl_pkg::MD_CLKOFF - 23];
  assign running = (st_r == pcm_ctl_pkg::FR_RUN);
  assign run_req = en_r & (tx_run_r | rx_run_r);

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      bclk_s1 <= bclk_i;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      din_s1 <= din_i;
      din_s2 <= din_s1;
    end
  end

  // ****************************************
  // bit clock source and edges
  // ****************************************
  // clock off stops divider only in the low phase so no runt pulse; enable low or slave stops it at once
  always_comb begin
    div_nxt = div_r;
    mb_nxt = mb_r;
    mrise = 1'b0;
    mfall = 1'b0;
    if (!en_r || slave || (clk_off && !mb_r)) begin
      div_nxt = '0;
      mb_nxt = 1'b0;
    end else if (div_r == DW'(HALF_DIV - 1)) begin
      div_nxt = '0;
      mb_nxt = ~mb_r;
      mrise = ~mb_r;
      mfall = mb_r;
    end else begin
      div_nxt = div_r + DW'(1);
    end
    if (slave) begin
      rise = en_r & ~clk_off & bclk_s2 & ~bclk_s3;
      fall = en_r & ~clk_off & ~bclk_s2 & bclk_s3;
    end else begin
      rise = mrise;
      fall = mfall;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= '0;
      mb_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      mb_r <= mb_nxt;
    end
  end

  // ****************************************
  // frame engine
  // ****************************************
  assign last = (bit_cnt_r == CW'(2 * CH_BITS - 1));

  always_comb begin
    st_nxt = st_r;
    bit_cnt_nxt = bit_cnt_r;
    tx_act_nxt = tx_act_r;
    rx_act_nxt = rx_act_r;
    tx_sh_nxt = tx_sh_r;
    tx_hold_nxt = tx_hold_r;
    rx_sh_nxt = rx_sh_r;
    rx_hold_nxt = rx_hold_r;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_push_data = '0;
    fstart = 1'b0;
    ch_start = 1'b0;
    if (!en_r) begin
      st_nxt = pcm_ctl_pkg::FR_IDLE;
      bit_cnt_nxt = '0;
      tx_act_nxt = 1'b0;
      rx_act_nxt = 1'b0;
      tx_sh_nxt = '0;
    end else begin
      if (rise) begin
        case (st_r)
          pcm_ctl_pkg::FR_IDLE: begin
            if (run_req) begin
              st_nxt = pcm_ctl_pkg::FR_RUN;
              bit_cnt_nxt = '0;
              fstart = 1'b1;
            end
          end
          pcm_ctl_pkg::FR_RUN: begin
            bit_cnt_nxt = last ? '0 : bit_cnt_r + CW'(1);
            fstart = last;
            ch_start = (bit_cnt_r == CW'(CH_BITS - 1));
            if (last && !run_req) begin
              st_nxt = pcm_ctl_pkg::FR_IDLE;
            end
          end
          default: begin
            st_nxt = pcm_ctl_pkg::FR_IDLE;
          end
        endcase
        if (fstart) begin
          tx_act_nxt = tx_run_r;
          rx_act_nxt = rx_run_r;
        end
        if ((fstart || ch_start) && tx_act_nxt) begin
          if (tx_packed && ch_start) begin
            tx_sh_nxt = CH_BITS'(tx_hold_r);
          end else if (tx_cnt_r != '0) begin
            tx_pop = 1'b1;
            tx_sh_nxt = tx_packed ? CH_BITS'(tx_ram.rdata[15:0]) : tx_ram.rdata[CH_BITS-1:0];
            tx_hold_nxt = tx_ram.rdata[31:16];
          end else begin
            tx_sh_nxt = '0;
            tx_hold_nxt = '0;
          end
        end else begin
          tx_sh_nxt = tx_sh_r << 1;
        end
      end
      if (fall && running && rx_act_r && !pdm) begin
        rx_sh_nxt = {rx_sh_r[CH_BITS-2:0], din_s2};
        if (bit_cnt_r[CW-2:0] == (CW-1)'(CH_BITS - 1)) begin
          if (!rx_packed) begin
            rx_push = 1'b1;
            rx_push_data = 32'(rx_sh_nxt);
          end else if (!bit_cnt_r[CW-1]) begin
            rx_hold_nxt = rx_sh_nxt[15:0];
          end else begin
            rx_push = 1'b1;
            rx_push_data = {rx_sh_nxt[15:0], rx_hold_r};
          end
        end
      end
      if (pdm && rx_act_r && cic_valid) begin
        rx_push = 1'b1;
        rx_push_data = 32'(cic_data);
      end
    end
    fs_nxt = (st_nxt == pcm_ctl_pkg::FR_RUN) && (bit_cnt_nxt == '0);
    dout_nxt = tx_act_nxt & tx_sh_nxt[CH_BITS-1];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= pcm_ctl_pkg::FR_IDLE;
      bit_cnt_r <= '0;
      tx_act_r <= 1'b0;
      rx_act_r <= 1'b0;
      tx_sh_r <= '0;
      tx_hold_r <= '0;
      rx_sh_r <= '0;
      rx_hold_r <= '0;
      fs_r <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      tx_act_r <= tx_act_nxt;
      rx_act_r <= rx_act_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_hold_r <= tx_hold_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_hold_r <= rx_hold_nxt;
      fs_r <= fs_nxt;
      dout_r <= dout_nxt;
    end
  end

  // ****************************************
  // density input decimator
  // ****************************************
  cic_decim u_cic (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(pdm & rx_act_r & en_r),
    .sample(fall & running & rx_act_r & pdm),
    .din(din_s2),
    .ratio_high(mode_r[pcm_ctl_pkg::MD_DEC - 23]),
    .valid(cic_valid),
    .data(cic_data)
  );

  // ****************************************
  // registers and fifo pointers
  // ****************************************
  assign wr_ctrl = reg_wr && reg_addr == pcm_ctl_pkg::OFF_CTRL;
  assign wr_data = reg_wr && reg_addr == pcm_ctl_pkg::OFF_DATA;
  assign wr_mode = reg_wr && reg_addr == pcm_ctl_pkg::OFF_MODE;
  assign rd_data = reg_rd && reg_addr == pcm_ctl_pkg::OFF_DATA;

  always_comb begin
    en_nxt = en_r;
    rx_run_nxt = rx_run_r;
    tx_run_nxt = tx_run_r;
    thr_nxt = thr_r;
    mode_nxt = mode_r;
    if (wr_ctrl) begin
      en_nxt = reg_wdata[pcm_ctl_pkg::CS_EN];
      rx_run_nxt = reg_wdata[pcm_ctl_pkg::CS_RX_RUN];
      tx_run_nxt = reg_wdata[pcm_ctl_pkg::CS_TX_RUN];
      if (!running) begin
        thr_nxt = reg_wdata[pcm_ctl_pkg::CS_THR_HI:pcm_ctl_pkg::CS_THR_LO];
      end
    end
    if (wr_mode && !running) begin
      mode_nxt = reg_wdata[pcm_ctl_pkg::MD_CLKOFF:pcm_ctl_pkg::MD_SLAVE];
    end
    tx_clr = wr_ctrl & reg_wdata[pcm_ctl_pkg::CS_TX_CLR];
    rx_clr = wr_ctrl & reg_wdata[pcm_ctl_pkg::CS_RX_CLR];
    tx_push = wr_data && tx_cnt_r != (AW+1)'(DEPTH);
    rx_pop = rd_data && rx_cnt_r != '0;
    tx_wp_nxt = tx_push ? tx_wp_r + AW'(1) : tx_wp_r;
    tx_rp_nxt = tx_pop ? tx_rp_r + AW'(1) : tx_rp_r;
    tx_cnt_nxt = tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    rx_wp_nxt = (rx_push && rx_cnt_r != (AW+1)'(DEPTH)) ? rx_wp_r + AW'(1) : rx_wp_r;
    rx_rp_nxt = rx_pop ? rx_rp_r + AW'(1) : rx_rp_r;
    rx_cnt_nxt = rx_cnt_r + (AW+1)'(rx_wp_nxt != rx_wp_r) - (AW+1)'(rx_pop);
    if (tx_clr) begin
      tx_wp_nxt = '0;
      tx_rp_nxt = '0;
      tx_cnt_nxt = '0;
    end
    if (rx_clr) begin
      rx_wp_nxt = '0;
      rx_rp_nxt = '0;
      rx_cnt_nxt = '0;
    end
    case (thr_r)
      pcm_ctl_pkg::THR_EMPTY: tx_needs_writing = (tx_cnt_r == '0);
      pcm_ctl_pkg::THR_QUARTER: tx_needs_writing = (tx_cnt_r < (AW+1)'(DEPTH / 4));
      default: tx_needs_writing = (tx_cnt_r < (AW+1)'(DEPTH - 1));
    endcase
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        pcm_ctl_pkg::OFF_CTRL: begin
          rdata_nxt[pcm_ctl_pkg::CS_EN] = en_r;
          rdata_nxt[pcm_ctl_pkg::CS_RX_RUN] = rx_run_r;
          rdata_nxt[pcm_ctl_pkg::CS_TX_RUN] = tx_run_r;
          rdata_nxt[pcm_ctl_pkg::CS_THR_HI:pcm_ctl_pkg::CS_THR_LO] = thr_r;
          rdata_nxt[pcm_ctl_pkg::CS_TXW] = tx_needs_writing;
          rdata_nxt[pcm_ctl_pkg::CS_TXD] = (tx_cnt_r != (AW+1)'(DEPTH));
          rdata_nxt[pcm_ctl_pkg::CS_RXD] = (rx_cnt_r != '0);
          rdata_nxt[pcm_ctl_pkg::CS_TXE] = (tx_cnt_r == '0);
          rdata_nxt[pcm_ctl_pkg::CS_RXF] = (rx_cnt_r == (AW+1)'(DEPTH));
        end
        pcm_ctl_pkg::OFF_DATA: rdata_nxt = rx_pop ? rx_ram.rdata : pcm_ctl_pkg::DATA_RST;
        pcm_ctl_pkg::OFF_MODE: rdata_nxt[pcm_ctl_pkg::MD_CLKOFF:pcm_ctl_pkg::MD_SLAVE] = mode_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 1'b0;
      rx_run_r <= 1'b0;
      tx_run_r <= 1'b0;
      thr_r <= pcm_ctl_pkg::THR_RST;
      mode_r <= pcm_ctl_pkg::MODE_RST;
      rdata_r <= '0;
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      en_r <= en_nxt;
      rx_run_r <= rx_run_nxt;
      tx_run_r <= tx_run_nxt;
      thr_r <= thr_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
      tx_wp_r <= tx_wp_nxt;
      tx_rp_r <= tx_rp_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      rx_wp_r <= rx_wp_nxt;
      rx_rp_r <= rx_rp_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // ****************************************
  // fifo storage
  // ****************************************
  // read address runs one step ahead so back-to-back pops see fresh data
  assign tx_ram.we = tx_push;
  assign tx_ram.waddr = tx_wp_r;
  assign tx_ram.wdata = reg_wdata;
  assign tx_ram.raddr = tx_rp_nxt;
  assign rx_ram.we = rx_wp_nxt != rx_wp_r && !rx_clr;
  assign rx_ram.waddr = rx_wp_r;
  assign rx_ram.wdata = rx_push_data;
  assign rx_ram.raddr = rx_rp_nxt;

  fifo_mem #(.W(32), .AW(AW)) u_tx_mem (
    .core_clk(core_clk),
    .resetn(resetn),
    .port(tx_ram)
  );

  fifo_mem #(.W(32), .AW(AW)) u_rx_mem (
    .core_clk(core_clk),
    .resetn(resetn),
    .port(rx_ram)
  );

  // outputs
  assign reg_rdata = rdata_r;
  assign bclk_o = mb_r;
  assign bclk_oe = en_r & ~slave;
  assign fs_o = fs_r;
  assign dout_o = dout_r;
endmodule : audio_pcm_control_mode

// ===== dv/audio_pcm_control_mode_sva.sv
`timescale 1ns/1ns
// ****************************************
// port checker
// ****************************************
module audio_pcm_control_mode_sva #(
  parameter int DEPTH = 64,
  parameter int CH_BITS = 32,
  parameter int HALF_DIV = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic bclk_i,
  input wire logic bclk_o,
  input wire logic bclk_oe,
  input wire logic fs_o,
  input wire logic dout_o,
  input wire logic din_i
);
  logic en_r;
  logic en_nxt;
  logic rd_ctrl;
  // global enable shadow
  always_comb begin
    en_nxt = en_r;
    if (reg_wr && reg_addr == pcm_ctl_pkg::OFF_CTRL) begin
      en_nxt = reg_wdata[pcm_ctl_pkg::CS_EN];
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end
  // read decodes
  assign rd_ctrl = reg_rd && reg_addr == pcm_ctl_pkg::OFF_CTRL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero");
  a_clear_reads_zero: assert property (rd_ctrl |=> reg_rdata[4:3] == 2'h0)
    else $error("clear bits read set");
  a_empty_needs_fill: assert property (rd_ctrl |=> !reg_rdata[pcm_ctl_pkg::CS_TXE] ||
    (reg_rdata[pcm_ctl_pkg::CS_TXW] && reg_rdata[pcm_ctl_pkg::CS_TXD]))
    else $error("empty tx fifo flags");
  a_off_no_drive: assert property (rd_ctrl ##1 !reg_rdata[pcm_ctl_pkg::CS_EN] |-> !bclk_oe)
    else $error("bit clock driven when off");
  a_slave_released: assert property ((reg_rd && reg_addr == pcm_ctl_pkg::OFF_MODE) ##1
    reg_rdata[pcm_ctl_pkg::MD_SLAVE] |-> !bclk_oe)
    else $error("bit clock driven as slave");
  a_off_quiet: assert property (!en_r ##1 !en_r |-> !bclk_o && !fs_o && !dout_o)
    else $error("outputs active when off");
  // four core cycles a half bit
  a_fs_one_bit: assert property ($rose(fs_o) |-> fs_o[*8] ##1 !fs_o)
    else $error("frame sync length");
  a_bclk_half: assert property (disable iff (!resetn || !en_r) $rose(bclk_o) |-> bclk_o[*4] ##1 !bclk_o)
    else $error("bit clock high length");
endmodule : audio_pcm_control_mode_sva

bind audio_pcm_control_mode audio_pcm_control_mode_sva #(.DEPTH(DEPTH), .CH_BITS(CH_BITS), .HALF_DIV(HALF_DIV))
  u_audio_pcm_control_mode_sva (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_i(bclk_i), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
  .fs_o(fs_o), .dout_o(dout_o), .din_i(din_i));

// ===== dv/codec_model.sv
`timescale 1ns/1ns
// ****************************************
// far-side serial codec
// ****************************************
module codec_model (
  input wire logic bclk,
  input wire logic fs,
  input wire logic dout,
  input wire logic clk_run,
  input wire logic ones_only,
  output logic codec_clk,
  output logic din
);
  localparam logic [63:0] PATTERN = 64'h9e3779b97f4a7c15;
  logic [63:0] frames [0:15];
  logic [63:0] cap_sh = 64'h0;
  logic fs_n = 1'b0;
  int nframes = 0;
  int cap_cnt = 0;
  int bit_idx = 0;
  // slave-mode bit clock, still unless asked to run
  initial begin
    codec_clk = 1'b0;
    din = 1'b0;
    #13;
    forever begin
      #200;
      codec_clk = clk_run ? ~codec_clk : 1'b0;
    end
  end
  // data out at each rise, msb first
  always @(posedge bclk) begin
    if (ones_only) begin
      din <= 1'b1;
    end else begin
      din <= PATTERN[fs_n ? 62 : 63 - bit_idx];
      bit_idx <= fs_n ? 2 : bit_idx == 0 ? 0 : (bit_idx + 1) % 64;
    end
  end
  // capture at each fall
  always @(negedge bclk) begin
    fs_n <= fs;
    if (fs) begin
      cap_sh <= {63'h0, dout};
      cap_cnt <= 1;
    end else if (cap_cnt != 0) begin
      cap_sh <= {cap_sh[62:0], dout};
      cap_cnt <= (cap_cnt + 1) % 64;
      if (cap_cnt == 63 && nframes < 16) begin
        frames[nframes] <= {cap_sh[62:0], dout};
        nframes <= nframes + 1;
      end
    end
  end
endmodule : codec_model

// ===== dv/audio_pcm_control_mode_test.sv
`timescale 1ns/1ns
// ****************************************
// register-level test
// ****************************************
module audio_pcm_control_mode_test;
  localparam int DEPTH = 8;
  localparam logic [31:0] W0 = 32'h13579bdf;
  localparam logic [31:0] W1 = 32'h2468ace0;
  localparam logic [31:0] W2 = 32'hcafe1234;
  logic core_clk;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic bclk_o;
  logic bclk_oe;
  logic fs_o;
  logic dout_o;
  logic din_i;
  logic clk_run;
  logic ones_only;
  logic codec_clk;
  logic bclk_w;
  logic [31:0] rv;
  logic [63:0] pat;
  int err_count;
  int compares;
  // resolved bit clock wire
  assign bclk_w = bclk_oe ? bclk_o : codec_clk;
  assign pat = u_codec_model.PATTERN;
  audio_pcm_control_mode #(.DEPTH(DEPTH), .CH_BITS(32), .HALF_DIV(4)) u_audio_pcm_control_mode (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
    .fs_o(fs_o), .dout_o(dout_o), .din_i(din_i));
  codec_model u_codec_model (.bclk(bclk_w), .fs(fs_o), .dout(dout_o), .clk_run(clk_run),
    .ones_only(ones_only), .codec_clk(codec_clk), .din(din_i));
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  task automatic rises(input int n, output int c);
    logic prev;
    c = 0;
    prev = bclk_o;
    repeat (n) begin
      @(posedge core_clk);
      if (bclk_o && !prev) c++;
      prev = bclk_o;
    end
  endtask : rises
  task automatic wait_frames(input int n);
    int i;
    for (i = 0; i < 5000 && u_codec_model.nframes < n; i++) @(posedge core_clk);
    if (i >= 5000) begin
      chk("frame wait", 32'(u_codec_model.nframes), 32'(n));
      results();
    end
  endtask : wait_frames
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // main sequence
  initial begin
    int t;
    int n;
    int c;
    int base;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    clk_run = 1'b0;
    ones_only = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rd(pcm_ctl_pkg::OFF_CTRL, rv);
    chk("control reset", rv, 32'h002a0000);
    rd(pcm_ctl_pkg::OFF_MODE, rv);
    chk("mode reset", rv, 32'h0);
    rd(pcm_ctl_pkg::OFF_DATA, rv);
    chk("empty rx read", rv, 32'h0);
    rd(8'h0c, rv);
    chk("unmapped read", rv, 32'h0);
    // every threshold code at every fill level
    for (t = 0; t < 4; t++) begin
      wr(pcm_ctl_pkg::OFF_CTRL, 32'(t << 5) | 32'h8);
      for (n = 0; n <= DEPTH; n++) begin
        rd(pcm_ctl_pkg::OFF_CTRL, rv);
        chk("needs writing", 32'(rv[17]), 32'(t == 0 ? n == 0 : t == 1 ? n < DEPTH / 4 : n < DEPTH - 1));
        chk("tx space", 32'(rv[19]), 32'(n < DEPTH));
        wr(pcm_ctl_pkg::OFF_DATA, 32'h100 + 32'(n));
      end
    end
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h8);
    rd(pcm_ctl_pkg::OFF_CTRL, rv);
    chk("tx cleared", 32'(rv[21]), 32'h1);
    rises(40, c);
    chk("clock disabled", 32'(c), 32'h0);
    wr(pcm_ctl_pkg::OFF_MODE, 32'h10000000);
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h1);
    rises(40, c);
    chk("clock off", 32'(c), 32'h0);
    wr(pcm_ctl_pkg::OFF_MODE, 32'h0);
    rises(40, c);
    chk("clock resumes", 32'(c >= 4), 32'h1);
    // master transmit and receive against the codec pattern, writes refused while running
    wr(pcm_ctl_pkg::OFF_DATA, W0);
    wr(pcm_ctl_pkg::OFF_DATA, W1);
    base = u_codec_model.nframes;
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h7);
    repeat (20) @(posedge core_clk);
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h47);
    wr(pcm_ctl_pkg::OFF_MODE, 32'h01000000);
    rd(pcm_ctl_pkg::OFF_CTRL, rv);
    chk("threshold", 32'(rv[6:5]), 32'h0);
    rd(pcm_ctl_pkg::OFF_MODE, rv);
    chk("mode frozen", rv, 32'h0);
    wait_frames(base + 2);
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h1);
    repeat (700) @(posedge core_clk);
    n = u_codec_model.nframes;
    chk("first channel", u_codec_model.frames[base][63:32], W0);
    chk("second channel", u_codec_model.frames[base][31:0], W1);
    chk("underflow", u_codec_model.frames[base + 1][63:32], 32'h0);
    repeat (600) @(posedge core_clk);
    chk("tx stopped", 32'(u_codec_model.nframes), 32'(n));
    for (t = 0; t < 4; t++) begin
      rd(pcm_ctl_pkg::OFF_DATA, rv);
      chk("rx word", rv, t[0] ? pat[31:0] : pat[63:32]);
    end
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h11);
    rd(pcm_ctl_pkg::OFF_CTRL, rv);
    chk("rx cleared", 32'(rv[20]), 32'h0);
    // transmit packed mode
    wr(pcm_ctl_pkg::OFF_MODE, 32'h01000000);
    wr(pcm_ctl_pkg::OFF_DATA, W2);
    base = u_codec_model.nframes;
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h5);
    wait_frames(base + 1);
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h1);
    repeat (700) @(posedge core_clk);
    chk("packed low", u_codec_model.frames[base][63:32], {16'h0, W2[15:0]});
    chk("packed high", u_codec_model.frames[base][31:0], {16'h0, W2[31:16]});
    // slave clock, receive packed
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h0);
    wr(pcm_ctl_pkg::OFF_MODE, 32'h02800000);
    rd(pcm_ctl_pkg::OFF_MODE, rv);
    chk("slave mode", rv, 32'h02800000);
    clk_run <= 1'b1;
    base = u_codec_model.nframes;
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h3);
    wait_frames(base + 2);
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h1);
    repeat (700) @(posedge core_clk);
    rd(pcm_ctl_pkg::OFF_DATA, rv);
    chk("rx packed", rv, {pat[15:0], pat[47:32]});
    clk_run <= 1'b0;
    wr(pcm_ctl_pkg::OFF_CTRL, 32'h0);
    // density input, both ratios
    ones_only <= 1'b1;
    for (t = 0; t < 2; t++) begin
      wr(pcm_ctl_pkg::OFF_MODE, 32'h04000000 | 32'(t << 27));
      wr(pcm_ctl_pkg::OFF_CTRL, 32'h13);
      repeat (600) @(posedge core_clk);
      wr(pcm_ctl_pkg::OFF_CTRL, 32'h1);
      repeat (700) @(posedge core_clk);
      rd(pcm_ctl_pkg::OFF_DATA, rv);
      rd(pcm_ctl_pkg::OFF_DATA, rv);
      chk("density", rv, t == 0 ? 32'h10 : 32'h20);
      wr(pcm_ctl_pkg::OFF_CTRL, 32'h0);
    end
    results();
  end
endmodule : audio_pcm_control_mode_test
